// File: rtl/psp_top.sv
`timescale 1ns/100ps
// Summary of operation
// R1 - clock_qualify_n high at an edge: ignore the edge, hold all state; the code still runs sleep sequencing and write queue draining
// R2 - all inputs captured in registers on rising edge; outputs leave from registers
// R3 - all selects active with advance_or_load low loads address; write strobe picks type
// R4 - read data driven from output register at the next qualified edge if enabled
// R5 - after the first read cycle, drive needs internal control and output enable low
// R6 - a new read, write or deselect is accepted right after a read begins
// R7 - deselect at a load edge tristates data after the next qualified edge
// R8 - burst counter gives up to four accesses from one loaded address
// R9 - burst order strap: low is linear, high is interleaved
// R10 - counter touches only the two low address bits and wraps after four
// R11 - advance_or_load high advances the counter, selects and write strobe ignored
// R12 - write strobe captured only at load; access type kept for the whole burst
// R13 - write load registers address and byte-lane write selects
// R14 - edge after write address tristates data regardless of output enable
// R15 - write data captured at the second qualified edge after its address
// R16 - only byte lanes with active write selects are updated
// R17 - host must not drive data while device outputs are active
// R18 - sleep_request high enters data-retaining sleep; low for normal operation
// R19 - after deselect the host loads a fresh address rather than continuing
// R20 - first cycle after leaving deselect is tristated regardless of output enable
// R21 - interleaved order: start address xor beat index
// R22 - linear order: low bits increment by one modulo four
// R23 - sleep entry and exit take two cycles; device stays deselected meanwhile
// R24 - a stalled cycle keeps output register and drive state unchanged; the code still clears drive when sleep_request is high
module psp_top #(
  parameter int ADDR_W = psp_pkg::PSP_ADDR_W,
  parameter int LANES = psp_pkg::PSP_LANES,
  parameter int LANE_W = psp_pkg::PSP_LANE_W,
  parameter int FIFO_DEPTH = psp_pkg::PSP_FIFO_DEPTH
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clock_qualify_n_in,
  input wire logic select_one_n_in,
  input wire logic select_two_in,
  input wire logic select_three_n_in,
  input wire logic advance_or_load_in,
  input wire logic write_n_in,
  input wire logic [LANES-1:0] byte_lane_write_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic burst_order_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic [LANES*LANE_W-1:0] data_in,
  input wire logic [LANES-1:0] parity_lines_in,
  output logic [LANES*LANE_W-1:0] data_out,
  output logic [LANES-1:0] parity_lines_out,
  output logic data_oe_out,
  output logic sleep_active_out
);
  import psp_pkg::*;

  localparam int DW = LANES * LANE_W;
  localparam int FW = ADDR_W + DW + 2 * LANES;

  if (ADDR_W <= PSP_BURST_BITS || LANES < 1 || LANE_W < 1)
  begin : g_chk
    $error("address must be wider than the burst field and lanes non-empty");
  end

  psp_zz_state_t zz_state_q;
  logic [1:0] zz_cnt_q;
  logic sleep_q;
  logic awake;

  logic cur_act_q;
  logic cur_wr_q;
  logic mode_q;
  logic [1:0] beat_q;
  logic [ADDR_W-1:0] base_addr_q;
  logic [LANES-1:0] cur_lanes_q;
  logic [ADDR_W-1:0] cur_addr;

  logic s2_wr_q;
  logic [ADDR_W-1:0] s2_addr_q;
  logic [LANES-1:0] s2_lanes_q;

  logic [DW-1:0] dout_q;
  logic [LANES-1:0] dpar_q;
  logic drive_q;

  logic selected;
  logic load;
  logic edge_ok;
  logic qual;

  logic fill_valid;
  logic fill_ready;
  logic [FW-1:0] fill_word;
  logic [FW-1:0] drain_word;

  logic [DW-1:0] mem_data;
  logic [LANES-1:0] mem_par;
  logic [DW-1:0] rd_data;
  logic [LANES-1:0] rd_par;

  psp_wr_if #(.AW(ADDR_W), .NL(LANES), .LW(LANE_W)) wr_bus ();

  assign awake = (zz_state_q == PSP_AWAKE);
  assign selected = !select_one_n_in && select_two_in && !select_three_n_in;
  assign load = !advance_or_load_in;
  // a full write queue stalls the whole pipeline just like a disqualified edge, but only while a write waits in the data phase (s2_wr_q)
  assign edge_ok = !clock_qualify_n_in && awake; // see R1
  assign qual = edge_ok && (!s2_wr_q || fill_ready);
  assign cur_addr = {base_addr_q[ADDR_W-1:PSP_BURST_BITS],
                     psp_burst_low(base_addr_q[1:0], beat_q, mode_q)}; // see R10 see R21 see R22

  // sleep entry and exit sequencing
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      zz_state_q <= PSP_AWAKE;
      zz_cnt_q <= PSP_ZZ_FIRST;
    end
    else
    begin
      unique case (zz_state_q)
        PSP_AWAKE:
          if (sleep_request_in)
          begin
            zz_state_q <= PSP_ENTER; // see R18
            zz_cnt_q <= PSP_ZZ_FIRST;
          end
        PSP_ENTER:
          if (!sleep_request_in)
            zz_state_q <= PSP_AWAKE;
          else if (zz_cnt_q == PSP_ZZ_LAST)
            zz_state_q <= PSP_ASLEEP; // see R23
          else
            zz_cnt_q <= 2'(zz_cnt_q + 2'h1);
        PSP_ASLEEP:
          if (!sleep_request_in)
          begin
            zz_state_q <= PSP_WAKE;
            zz_cnt_q <= PSP_ZZ_FIRST;
          end
        PSP_WAKE:
          if (sleep_request_in)
            zz_state_q <= PSP_ASLEEP;
          else if (zz_cnt_q == PSP_ZZ_LAST)
            zz_state_q <= PSP_AWAKE; // see R23
          else
            zz_cnt_q <= 2'(zz_cnt_q + 2'h1);
      endcase
    end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
      sleep_q <= 1'b0;
    else
      sleep_q <= (zz_state_q == PSP_ENTER && sleep_request_in && zz_cnt_q == PSP_ZZ_LAST)
                 || (zz_state_q == PSP_ASLEEP)
                 || (zz_state_q == PSP_WAKE && (sleep_request_in || zz_cnt_q != PSP_ZZ_LAST));

  // access control: load, deselect and burst advance
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      cur_act_q <= 1'b0;
      cur_wr_q <= 1'b0;
      mode_q <= 1'b0;
      beat_q <= PSP_BEAT_FIRST;
    end
    else if (!awake)
      cur_act_q <= 1'b0;
    else if (qual)
    begin
      if (load)
      begin
        cur_act_q <= selected; // see R3 see R6
        beat_q <= PSP_BEAT_FIRST;
        if (selected)
        begin
          cur_wr_q <= !write_n_in; // see R12
          mode_q <= burst_order_in; // see R9
        end
      end
      else
        beat_q <= 2'(beat_q + PSP_BEAT_STEP); // see R8 see R11
    end

  // address register: high bits only change on a load
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
      base_addr_q <= '0;
    else if (qual && load && selected)
      base_addr_q <= addr_in; // see R13

  // byte-lane selects are sampled with every beat's address
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
      cur_lanes_q <= '0;
    else if (qual)
      cur_lanes_q <= ~byte_lane_write_n_in; // see R13

  // write data phase, one edge behind the address
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      s2_wr_q <= 1'b0;
      s2_addr_q <= '0;
      s2_lanes_q <= '0;
    end
    else if (!awake)
      s2_wr_q <= 1'b0;
    else if (qual)
    begin
      s2_wr_q <= cur_act_q && cur_wr_q; // see R15
      s2_addr_q <= cur_addr;
      s2_lanes_q <= cur_lanes_q;
    end

  // write data enters the queue at the second edge after its address
  assign fill_valid = edge_ok && s2_wr_q && (|s2_lanes_q); // see R15
  assign fill_word = {s2_addr_q, s2_lanes_q, parity_lines_in, data_in};

  psp_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(mclk_in),
    .rst_in(sys_rst_in),
    .in_valid_in(fill_valid),
    .in_ready_out(fill_ready),
    .in_data_in(fill_word),
    .out_valid_out(wr_bus.valid),
    .out_ready_in(wr_bus.ready),
    .out_data_out(drain_word)
  );

  assign wr_bus.data = drain_word[DW-1:0];
  assign wr_bus.par = drain_word[DW +: LANES];
  assign wr_bus.lanes = drain_word[DW+LANES +: LANES];
  assign wr_bus.addr = drain_word[DW+2*LANES +: ADDR_W];

  psp_mem #(.AW(ADDR_W), .NL(LANES), .LW(LANE_W)) u_mem (
    .clk_in(mclk_in),
    .drain_en_in(!sleep_q),
    .wr_if(wr_bus),
    .rd_addr_in(cur_addr),
    .rd_data_out(mem_data),
    .rd_par_out(mem_par)
  );

  // a write leaving the queue this cycle is forwarded to a read of the same word
  always_comb
  begin
    rd_data = mem_data;
    rd_par = mem_par;
    if (wr_bus.valid && wr_bus.ready && wr_bus.addr == cur_addr)
      for (int i = 0; i < LANES; i++)
        if (wr_bus.lanes[i])
        begin
          rd_data[i*LANE_W +: LANE_W] = wr_bus.data[i*LANE_W +: LANE_W];
          rd_par[i] = wr_bus.par[i];
        end
  end

  // output register
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      dout_q <= '0;
      dpar_q <= '0;
    end
    else if (qual && cur_act_q && !cur_wr_q) // see R24
    begin
      dout_q <= rd_data; // see R2
      dpar_q <= rd_par;
    end

  // output drive: held through stalls, cleared for writes, deselects and sleep
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
      drive_q <= 1'b0;
    else if (!awake || sleep_request_in)
      drive_q <= 1'b0;
    else if (qual)
      drive_q <= cur_act_q && !cur_wr_q && !output_enable_n_in; // see R4 see R5 see R7 see R14 see R20

  assign data_out = dout_q;
  assign parity_lines_out = dpar_q;
  assign data_oe_out = drive_q;
  assign sleep_active_out = sleep_q;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_stall_hold;
    clock_qualify_n_in && awake && !sleep_request_in
      |=> $stable(cur_act_q) && $stable(beat_q) && $stable(dout_q) && $stable(data_oe_out);
  endproperty
  a_stall_hold: assert property (p_stall_hold) // see R1 see R24
    else $error("stalled edge changed pipeline state");

  property p_read_drive;
    qual && cur_act_q && !cur_wr_q && !output_enable_n_in && !sleep_request_in
      |=> data_oe_out && data_out == $past(rd_data);
  endproperty
  a_read_drive: assert property (p_read_drive) // see R4
    else $error("read data not driven at the next qualified edge");

  property p_write_tristate;
    qual && cur_act_q && cur_wr_q |=> !data_oe_out;
  endproperty
  a_write_tristate: assert property (p_write_tristate) // see R14
    else $error("data driven in the cycle after a write address");

  property p_deselect;
    qual && load && !selected ##1 qual |=> !data_oe_out;
  endproperty
  a_deselect: assert property (p_deselect) // see R7
    else $error("outputs not tristated after a deselect");

  property p_load_type;
    qual && load && selected |=> cur_act_q && (cur_wr_q != $past(write_n_in)) && beat_q == PSP_BEAT_FIRST;
  endproperty
  a_load_type: assert property (p_load_type) // see R3
    else $error("load did not start an access of the strobed type");

  property p_burst_keeps;
    qual && !load |=> $stable(cur_wr_q) && $stable(base_addr_q);
  endproperty
  a_burst_keeps: assert property (p_burst_keeps) // see R11 see R12
    else $error("burst advance changed access type or upper address");

  property p_linear_step;
    qual && !load && cur_act_q && !mode_q |=> cur_addr[1:0] == 2'($past(cur_addr[1:0]) + 2'h1);
  endproperty
  a_linear_step: assert property (p_linear_step) // see R22
    else $error("linear burst did not step by one");

  property p_wrap;
    qual && !load && cur_act_q && beat_q == PSP_BEAT_LAST |=> cur_addr[1:0] == base_addr_q[1:0];
  endproperty
  a_wrap: assert property (p_wrap) // see R10 see R21
    else $error("burst did not wrap to its start after four beats");

  property p_data_capture;
    qual && cur_act_q && cur_wr_q && (|cur_lanes_q) ##1 edge_ok |-> fill_valid;
  endproperty
  a_data_capture: assert property (p_data_capture) // see R15
    else $error("write data not taken at the second edge");

  property p_sleep_entry;
    awake && sleep_request_in ##1 sleep_request_in [*2] |=> sleep_active_out && !data_oe_out;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) // see R18 see R23
    else $error("sleep not reached two cycles after request");
endmodule

// File: rtl/psp_pkg.sv
package psp_pkg;
  localparam int PSP_ADDR_W = 18;
  localparam int PSP_LANES = 4;
  localparam int PSP_LANE_W = 8;
  localparam int PSP_FIFO_DEPTH = 16;
  localparam int PSP_BURST_BITS = 2;
  localparam logic [1:0] PSP_BEAT_FIRST = 2'h0;
  localparam logic [1:0] PSP_BEAT_STEP = 2'h1;
  localparam logic [1:0] PSP_BEAT_LAST = 2'h3;
  // sleep entry and exit time, in clock periods
  localparam int PSP_ZZ_CYC = 2;
  localparam logic [1:0] PSP_ZZ_LAST = 2'(PSP_ZZ_CYC - 1);
  localparam logic [1:0] PSP_ZZ_FIRST = 2'h0;

  typedef enum {PSP_AWAKE, PSP_ENTER, PSP_ASLEEP, PSP_WAKE} psp_zz_state_t;

  // low two address bits for a given beat of a burst
  function automatic logic [1:0] psp_burst_low(input logic [1:0] start, input logic [1:0] beat,
                                               input logic interleave);
    psp_burst_low = interleave ? (start ^ beat) : 2'(start + beat);
  endfunction
endpackage

// File: rtl/psp_wr_if.sv
`timescale 1ns/100ps
interface psp_wr_if #(
  parameter int AW = 18,
  parameter int NL = 4,
  parameter int LW = 8
);
  logic valid;
  logic ready;
  logic [AW-1:0] addr;
  logic [NL*LW-1:0] data;
  logic [NL-1:0] par;
  logic [NL-1:0] lanes;
  modport src (output valid, output addr, output data, output par, output lanes, input ready);
  modport snk (input valid, input addr, input data, input par, input lanes, output ready);
endinterface

// File: rtl/psp_fifo.sv
`timescale 1ns/100ps
module psp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_chk
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [PW:0] wr_ptr_q;
  logic [PW:0] rd_ptr_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign push = in_valid_in && !full;
  assign pop = out_ready_in && !empty;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = buf_q[rd_ptr_q[PW-1:0]];

  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (PW+1)'(wr_ptr_q + 1'b1);
      if (pop)
        rd_ptr_q <= (PW+1)'(rd_ptr_q + 1'b1);
    end

  always_ff @(posedge clk_in)
    if (push)
      buf_q[wr_ptr_q[PW-1:0]] <= in_data_in;
endmodule

// File: rtl/psp_mem.sv
`timescale 1ns/100ps
module psp_mem #(
  parameter int AW = 18,
  parameter int NL = 4,
  parameter int LW = 8
) (
  input wire logic clk_in,
  input wire logic drain_en_in,
  psp_wr_if.snk wr_if,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [NL*LW-1:0] rd_data_out,
  output logic [NL-1:0] rd_par_out
);
  logic [NL*LW-1:0] data_q [2**AW];
  logic [NL-1:0] par_q [2**AW];

  // draining stops while asleep so queued writes wait in the fifo
  assign wr_if.ready = drain_en_in;
  assign rd_data_out = data_q[rd_addr_in];
  assign rd_par_out = par_q[rd_addr_in];

  always_ff @(posedge clk_in)
    if (wr_if.valid && drain_en_in)
      for (int i = 0; i < NL; i++)
        if (wr_if.lanes[i])
        begin
          data_q[wr_if.addr][i*LW +: LW] <= wr_if.data[i*LW +: LW]; // see R16
          par_q[wr_if.addr][i] <= wr_if.par[i];
        end
endmodule

// File: tb/psp_host_bus.sv
`timescale 1ns/100ps
module psp_host_bus (
  input wire logic clk_in,
  input wire logic host_drive_in,
  input wire logic [35:0] host_word_in,
  input wire logic dev_drive_in,
  input wire logic [35:0] dev_word_in,
  output logic [35:0] bus_word_out,
  output logic clash_out
);
  logic [35:0] last_q = 36'h0;

  // a released bus shows the inverse of the previous cycle's word, so it alternates between the last driven word and its inverse
  always_comb
  begin
    if (host_drive_in)
      bus_word_out = host_word_in;
    else if (dev_drive_in)
      bus_word_out = dev_word_in;
    else
      bus_word_out = ~last_q;
  end

  always @(posedge clk_in)
    last_q <= bus_word_out;

  // both parties driving the shared lines at once
  assign clash_out = host_drive_in & dev_drive_in;
endmodule

// File: tb/test_pipelined_burst_sram_port.sv
`timescale 1ns/100ps
module test_pipelined_burst_sram_port;
  import psp_pkg::*;
  localparam logic [13:0] ADDR_HI = 14'h2B7;
  localparam logic L = 1'b0;
  localparam logic H = 1'b1;
  logic mclk_in, sys_rst_in, clock_qualify_n_in, select_one_n_in, select_two_in, select_three_n_in;
  logic advance_or_load_in, write_n_in, burst_order_in, output_enable_n_in, sleep_request_in;
  logic [3:0] byte_lane_write_n_in, parity_lines_out, wa_l, wb_l;
  logic [17:0] addr_in, rd_a, wa_a, wb_a, st_a;
  logic [31:0] data_out;
  logic data_oe_out, sleep_active_out, host_drive, clash;
  logic [35:0] host_word, bus_word;
  logic [35:0] ref_mem [logic [17:0]];
  logic [35:0] exp_word = 36'h0;
  logic exp_oe = 1'b0, rd_v = 1'b0, wa_v = 1'b0, wb_v = 1'b0, act = 1'b0, bwr = 1'b0, ilv = 1'b0;
  logic [1:0] beat = 2'h0;
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 95151;

  psp_top u_psp_top (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clock_qualify_n_in(clock_qualify_n_in),
    .select_one_n_in(select_one_n_in), .select_two_in(select_two_in), .select_three_n_in(select_three_n_in),
    .advance_or_load_in(advance_or_load_in), .write_n_in(write_n_in), .byte_lane_write_n_in(byte_lane_write_n_in),
    .addr_in(addr_in), .burst_order_in(burst_order_in), .output_enable_n_in(output_enable_n_in),
    .sleep_request_in(sleep_request_in), .data_in(bus_word[31:0]), .parity_lines_in(bus_word[35:32]),
    .data_out(data_out), .parity_lines_out(parity_lines_out), .data_oe_out(data_oe_out),
    .sleep_active_out(sleep_active_out));

  psp_host_bus u_psp_host_bus (.clk_in(mclk_in), .host_drive_in(host_drive), .host_word_in(host_word),
    .dev_drive_in(data_oe_out), .dev_word_in({parity_lines_out, data_out}), .bus_word_out(bus_word),
    .clash_out(clash));

  function automatic logic [17:0] beat_addr(input logic [17:0] s, input logic [1:0] b, input logic il);
    beat_addr = s;
    beat_addr[1:0] = il ? (s[1:0] ^ b) : (s[1:0] + b);
  endfunction

  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw, input logic [3:0] ln_n);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (!ln_n[i])
      begin
        merge[8*i+:8] = nw[8*i+:8];
        merge[32+i] = nw[32+i];
      end
  endfunction

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one edge of the reference pipeline, then compare the outputs it predicts
  task automatic step();
    // mid-cycle: host write data and device read drive must never overlap
    @(negedge mclk_in);
    chk({35'h0, clash}, 36'h0);
    @(posedge mclk_in);
    #1;
    if (!clock_qualify_n_in)
    begin
      exp_oe = rd_v & ~output_enable_n_in;
      if (exp_oe)
        exp_word = ref_mem[rd_a];
      if (wb_v)
        ref_mem[wb_a] = merge(ref_mem[wb_a], bus_word, wb_l);
      wb_v = wa_v;
      wb_a = wa_a;
      wb_l = wa_l;
      if (!advance_or_load_in)
      begin
        act = !select_one_n_in && select_two_in && !select_three_n_in;
        bwr = !write_n_in;
        st_a = addr_in;
        ilv = burst_order_in;
        beat = PSP_BEAT_FIRST;
      end
      else
        beat = beat + 2'h1;
      rd_v = act & ~bwr;
      wa_v = act & bwr;
      wa_a = beat_addr(st_a, beat, ilv);
      wa_l = byte_lane_write_n_in;
      rd_a = wa_a;
    end
    chk({35'h0, data_oe_out}, {35'h0, exp_oe});
    if (exp_oe)
      chk({parity_lines_out, data_out}, exp_word);
  endtask

  task automatic op(input logic stl, adv, sel, wr_n, input logic [3:0] ln_n, lo, input logic ord, oe_n);
    logic [31:0] pick;
    pick = $random(seed);
    host_drive = wb_v;
    host_word = {4'($random(seed)), 32'($random(seed))};
    clock_qualify_n_in = stl;
    advance_or_load_in = adv;
    select_one_n_in = !sel && pick[1:0] == 2'h0;
    select_two_in = !(!sel && pick[1:0] == 2'h1);
    select_three_n_in = !sel && pick[1];
    write_n_in = wr_n;
    byte_lane_write_n_in = ln_n;
    addr_in = {ADDR_HI, lo};
    burst_order_in = ord;
    output_enable_n_in = oe_n;
    step();
  endtask

  task automatic wait_sleep(input logic lvl);
    int n;
    n = 0;
    while (sleep_active_out !== lvl && n < 8)
    begin
      @(posedge mclk_in);
      #1;
      n++;
      chk({35'h0, data_oe_out}, 36'h0);
    end
    chk({35'h0, sleep_active_out}, {35'h0, lvl});
    chk(36'(n >= PSP_ZZ_CYC), 36'h1);
  endtask

  initial
  begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  initial
  begin
    #40000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    logic [31:0] r;
    sys_rst_in = H;
    sleep_request_in = L;
    host_drive = L;
    host_word = 36'h0;
    clock_qualify_n_in = L;
    advance_or_load_in = L;
    select_one_n_in = H;
    select_two_in = L;
    select_three_n_in = H;
    write_n_in = H;
    byte_lane_write_n_in = 4'hF;
    addr_in = 18'h0;
    burst_order_in = L;
    output_enable_n_in = L;
    repeat (16) @(posedge mclk_in);
    #1;
    sys_rst_in = L;
    chk({parity_lines_out, data_out}, 36'h0);
    chk({34'h0, data_oe_out, sleep_active_out}, 36'h0);
    // back-to-back full writes fill the test region
    for (int i = 0; i < 16; i++)
      op(L, L, H, L, 4'h0, 4'(i), L, L);
    // linear then interleaved read bursts; selects, strobe and order ignored while advancing
    for (int m = 0; m < 2; m++)
    begin
      op(L, L, H, H, 4'hF, 4'h6 + 4'(m), m[0], L);
      for (int b = 0; b < 4; b++)
        op(b == 1, H, L, L, 4'hF, 4'h0, !m[0], L);
    end
    // write burst with changing byte lanes, then read it back with one dummy beat
    op(L, L, H, L, 4'h5, 4'h9, H, L);
    for (int b = 0; b < 3; b++)
      op(L, H, H, H, 4'(b * 5), 4'h0, L, L);
    op(L, L, H, H, 4'hF, 4'h9, H, L);
    for (int b = 0; b < 3; b++)
      op(L, H, L, L, 4'hF, 4'h0, L, b == 1);
    for (int i = 0; i < 3; i++)
      op(L, L, L, H, 4'hF, 4'h0, L, L);
    sleep_request_in = H;
    wait_sleep(H);
    sleep_request_in = L;
    wait_sleep(L);
    for (int i = 0; i < 2; i++)
      op(L, L, L, H, 4'hF, 4'h0, L, L);
    // every word survives sleep
    for (int i = 0; i < 16; i++)
      op(L, L, H, H, 4'hF, 4'(i), L, L);
    for (int n = 0; n < 3000; n++)
    begin
      r = $random(seed);
      op(r[2:0] == 3'h0, act & r[3] & (beat != PSP_BEAT_LAST), r[6:4] != 3'h0, r[7], r[11:8], r[15:12], r[16],
         r[19:17] == 3'h0);
    end
    tally_and_finish();
  end
endmodule
